/* File: rtl/pkrc_pkg.sv */
/*
 * constants, register map and types for the power key, host reset and
 * interrupt control block.
 * assumes a 100 MHz core clock and a 32-bit apb register port.
 */
package pkrc_pkg;
   // clock and the one millisecond time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_NS  = 1000000;
   localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_TIMER_MAX_MS = 1000;      // longest reset timer, 1 s

   // field widths
   localparam int APB_AW = 12;
   localparam int DB_W   = 8;                   // debounce time, ms
   localparam int KD_W   = 12;                  // long-press time, ms
   localparam int RT_W   = 10;                  // reset timer, ms
   localparam int TC_W   = 32;
   localparam int NIN    = 2;                   // debounced inputs
   localparam int IN_KEY = 0;
   localparam int IN_RRQ = 1;

   // register offsets
   localparam logic [APB_AW-1:0] ADDR_CTRL   = 12'h000;
   localparam logic [APB_AW-1:0] ADDR_TIMING = 12'h004;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
   localparam logic [APB_AW-1:0] ADDR_EVENT  = 12'h00C;
   localparam logic [APB_AW-1:0] ADDR_FAULT  = 12'h010;
   localparam logic [APB_AW-1:0] ADDR_PRESS  = 12'h014;

   // control register bits
   localparam int C_MODE_LSB = 0;               // two bits
   localparam int C_MASK     = 2;
   localparam int C_LOCK     = 3;
   localparam int C_FAST     = 4;
   localparam int C_ODRAIN   = 5;
   localparam int C_POFFRST  = 6;
   localparam int C_IRQHIGH  = 7;
   localparam int C_TRIG_LSB = 8;               // two bits
   localparam int C_SYSRUN   = 10;
   localparam int C_LOWPWR   = 11;

   // timing register fields
   localparam int T_DB_LSB = 0;
   localparam int T_KD_LSB = 8;
   localparam int T_RT_LSB = 20;
   localparam logic [DB_W-1:0] DB_RST = 8'h0A;
   localparam logic [KD_W-1:0] KD_RST = 12'h7D0;
   localparam logic [RT_W-1:0] RT_RST = 10'h014;

   // status register bits
   localparam int S_KEYLVL  = 0;
   localparam int S_KEYDOWN = 1;
   localparam int S_HOSTRST = 2;
   localparam int S_RRQLVL  = 3;
   localparam int S_PEND    = 4;

   typedef enum logic [1:0] {
      PKRC_MODE_EVENT = 2'h0,
      PKRC_MODE_LOCK  = 2'h1,
      PKRC_MODE_OFF   = 2'h2,
      PKRC_MODE_STBY  = 2'h3
   } pkrc_mode_e;

   typedef enum logic [1:0] {
      PKRC_TRIG_WAKE  = 2'h0,
      PKRC_TRIG_FIRST = 2'h1,
      PKRC_TRIG_SECND = 2'h2,
      PKRC_TRIG_POFF  = 2'h3
   } pkrc_trig_e;

   typedef enum logic [2:0] {
      PKRC_KEY_IDLE = 3'b001,
      PKRC_KEY_TIME = 3'b010,
      PKRC_KEY_LONG = 3'b100
   } pkrc_key_e;
endpackage

/* File: rtl/pkrc_top.sv */
/*
 * power key debounce and press timing, reset request handling, host reset
 * output with its release timer, level interrupt with pending events, and
 * the apb register slave that reaches all of them.
 * assumes inputs synchronous to mclk and a power sequencer outside that
 * reports its state and phase ends as one-cycle pulses.
 */
`timescale 1ns/1ns
module pkrc_top
   import pkrc_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              powerKeyIn,
   input  wire logic              resetRequestIn,
   input  wire logic              powerOffState,
   input  wire logic              seqBusy,
   input  wire logic              externalWakeTrigger,
   input  wire logic              firstSubseqDone,
   input  wire logic              secondSubseqDone,
   input  wire logic              resetToPoweroffDone,
   input  wire logic              shutdownResetStart,
   input  wire logic              shutdownPoweroffStart,
   output logic                   wakeReq,
   output logic                   resetModeReq,
   output logic                   fastShutdown,
   output logic                   systemRunReq,
   output logic                   lowPowerReq,
   output logic                   hostResetOut,
   output logic                   hostResetOe,
   output logic                   irqOut,
   output logic                   irqOe
);

   typedef struct packed {
      logic [TC_W-1:0]           tickCnt;
      logic                      tick;
      logic [NIN-1:0]            stable;
      logic [NIN-1:0][DB_W-1:0]  dbCnt;
      logic [11:0]               ctrl;
      logic [DB_W-1:0]           debounceSel;
      logic [KD_W-1:0]           keyDelay;
      logic [RT_W-1:0]           resetTimer;
      pkrc_key_e                 keySt;
      logic [KD_W-1:0]           keyCnt;
      logic [KD_W-1:0]           pressLen;
      logic                      keyEvent;
      logic                      keyPend;
      logic                      resetReqFault;
      logic                      hostRstAct;
      logic                      rtRun;
      logic [RT_W-1:0]           rtCnt;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
      logic                      wakeReq;
      logic                      resetModeReq;
      logic                      hostResetOut;
      logic                      hostResetOe;
      logic                      irqOut;
      logic                      irqOe;
   } pkrc_state_s;

   pkrc_state_s st_r;
   pkrc_state_s st_nxt;

   // true when an apb address names a mapped register
   function automatic logic pkrcMapped(input logic [APB_AW-1:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_TIMING) || (a == ADDR_STATUS) ||
             (a == ADDR_EVENT) || (a == ADDR_FAULT) || (a == ADDR_PRESS);
   endfunction

   // next state of the whole block
   always_comb begin
      logic [NIN-1:0] rawIn;
      logic           keyPrev;
      logic           rrqPrev;
      logic           newEvent;
      logic           longWake;
      logic           shortWake;
      logic           wrStb;
      logic           trigHit;
      logic           blockEvt;
      logic           irqAct;
      logic [31:0]    rd;
      pkrc_mode_e     mode;
      rawIn     = {resetRequestIn, powerKeyIn};
      keyPrev   = st_r.stable[IN_KEY];
      rrqPrev   = st_r.stable[IN_RRQ];
      newEvent  = 1'b0;
      longWake  = 1'b0;
      shortWake = 1'b0;
      trigHit   = 1'b0;
      rd        = 32'h0000_0000;
      st_nxt    = st_r;
      mode      = pkrc_mode_e'(st_r.ctrl[C_MODE_LSB +: 2]);
      st_nxt.wakeReq      = 1'b0;
      st_nxt.resetModeReq = 1'b0;

      // one millisecond time base
      st_nxt.tick = (st_r.tickCnt == TC_W'(MS_CYCLES - 1));
      st_nxt.tickCnt = st_nxt.tick ? '0 : st_r.tickCnt + TC_W'(1);

      // debounce filters sharing one time setting
      for (int i = 0; i < NIN; i++) begin
         if (rawIn[i] == st_r.stable[i]) begin
            st_nxt.dbCnt[i] = '0;
         end else if (st_r.dbCnt[i] >= st_r.debounceSel) begin
            st_nxt.stable[i] = rawIn[i];
            st_nxt.dbCnt[i]  = '0;
         end else if (st_r.tick) begin
            st_nxt.dbCnt[i] = st_r.dbCnt[i] + DB_W'(1);
         end
      end

      // key press timing, both edges, in every power mode
      unique case (st_r.keySt)
         // idle: wait for the debounced falling edge of the key
         PKRC_KEY_IDLE: begin
            if (keyPrev && !st_nxt.stable[IN_KEY]) begin
               st_nxt.keyCnt = '0;
               if (mode == PKRC_MODE_EVENT) begin
                  newEvent  = 1'b1;
                  shortWake = 1'b1;
                  st_nxt.keySt = PKRC_KEY_LONG;
               end else begin
                  st_nxt.keySt = PKRC_KEY_TIME;
               end
            end
         end
         // timing: release before the long-press time is a short press
         PKRC_KEY_TIME: begin
            if (st_nxt.stable[IN_KEY]) begin
               st_nxt.pressLen = st_r.keyCnt;
               newEvent  = 1'b1;
               shortWake = 1'b1;
               if (mode == PKRC_MODE_STBY) begin
                  st_nxt.ctrl[C_SYSRUN] = 1'b0;
                  st_nxt.ctrl[C_LOWPWR] = 1'b1;
               end
               st_nxt.keySt = PKRC_KEY_IDLE;
            end else if (st_r.keyCnt >= st_r.keyDelay) begin
               newEvent = 1'b1;
               longWake = 1'b1;
               st_nxt.ctrl[C_LOCK] = 1'b1;
               if (mode == PKRC_MODE_OFF || mode == PKRC_MODE_STBY) begin
                  st_nxt.ctrl[C_SYSRUN] = 1'b0;
               end
               if (mode == PKRC_MODE_STBY) begin
                  st_nxt.ctrl[C_LOWPWR] = 1'b0;
               end
               st_nxt.keySt = PKRC_KEY_LONG;
            end else if (st_r.tick) begin
               st_nxt.keyCnt = st_r.keyCnt + KD_W'(1);
            end
         end
         // long or mode 00 press: only wait for release, counter saturates
         PKRC_KEY_LONG: begin
            if (st_nxt.stable[IN_KEY]) begin
               st_nxt.pressLen = st_r.keyCnt;
               st_nxt.keySt    = PKRC_KEY_IDLE;
            end else if (st_r.tick && st_r.keyCnt != '1) begin
               st_nxt.keyCnt = st_r.keyCnt + KD_W'(1);
            end
         end
      endcase

      // wake-up from power-off, gated by mask; lock gates short presses and every mode 00 press, a long press in the other modes wakes through it
      if (powerOffState && !st_r.ctrl[C_MASK]) begin
         st_nxt.wakeReq = longWake || (shortWake && !st_r.ctrl[C_LOCK]);
      end

      // reset request: fault log, host reset, reset mode request
      if (rrqPrev && !st_nxt.stable[IN_RRQ]) begin
         st_nxt.resetReqFault = 1'b1;
         st_nxt.resetModeReq  = 1'b1;
      end

      // apb slave: answer prepared in setup, taken in access
      wrStb = psel && penable && st_r.pready && pwrite;
      st_nxt.pready  = psel && !penable;
      st_nxt.pslverr = psel && !penable && !pkrcMapped(paddr);
      // read mux, unmapped offsets read as zero
      unique case (paddr)
         ADDR_CTRL:   rd[11:0] = st_r.ctrl;
         ADDR_TIMING: begin
            rd[T_DB_LSB +: DB_W] = st_r.debounceSel;
            rd[T_KD_LSB +: KD_W] = st_r.keyDelay;
            rd[T_RT_LSB +: RT_W] = st_r.resetTimer;
         end
         ADDR_STATUS: begin
            rd[S_KEYLVL]  = st_r.stable[IN_KEY];
            rd[S_KEYDOWN] = !st_r.stable[IN_KEY];
            rd[S_HOSTRST] = st_r.hostRstAct;
            rd[S_RRQLVL]  = st_r.stable[IN_RRQ];
            rd[S_PEND]    = st_r.keyPend;
         end
         ADDR_EVENT:  rd[0] = st_r.keyEvent;
         ADDR_FAULT:  rd[0] = st_r.resetReqFault;
         ADDR_PRESS:  rd[KD_W-1:0] = st_r.pressLen;
         default:     rd = 32'h0000_0000;
      endcase
      // read data captured in setup, held until the next read
      st_nxt.prdata = (psel && !penable && !pwrite) ? rd : st_r.prdata;
      // register writes; a hardware set of lock, event or fault in the same cycle wins, key updates of sysrun and lowpwr are lost
      if (wrStb) begin
         unique case (paddr)
            ADDR_CTRL: begin
               st_nxt.ctrl = pwdata[11:0];
               if (st_r.keySt == PKRC_KEY_TIME && st_r.keyCnt >= st_r.keyDelay) begin
                  st_nxt.ctrl[C_LOCK] = 1'b1;                        // hardware set wins
               end
            end
            ADDR_TIMING: begin
               st_nxt.debounceSel = pwdata[T_DB_LSB +: DB_W];
               st_nxt.keyDelay    = pwdata[T_KD_LSB +: KD_W];
               // reset timer settings beyond one second are clamped
               st_nxt.resetTimer  = (pwdata[T_RT_LSB +: RT_W] > RT_W'(RST_TIMER_MAX_MS)) ?
                                    RT_W'(RST_TIMER_MAX_MS) : pwdata[T_RT_LSB +: RT_W];
            end
            ADDR_EVENT: if (pwdata[0]) st_nxt.keyEvent = 1'b0;
            ADDR_FAULT: if (pwdata[0] && !st_nxt.resetReqFault) st_nxt.resetReqFault = 1'b0;
            default: ;
         endcase
         // fault log cleared only when no new request lands this cycle
         if (paddr == ADDR_FAULT && pwdata[0] && !(rrqPrev && !st_nxt.stable[IN_RRQ])) begin
            st_nxt.resetReqFault = 1'b0;
         end
      end

      // events held while the event register is read or sequencer moves
      blockEvt = (psel && paddr == ADDR_EVENT && !pwrite) || seqBusy;
      if (newEvent || st_r.keyPend) begin
         if (blockEvt) begin
            st_nxt.keyPend = 1'b1;
         end else begin
            st_nxt.keyEvent = 1'b1;
            st_nxt.keyPend  = 1'b0;
         end
      end

      // host reset assertion sources
      if (shutdownResetStart || (rrqPrev && !st_nxt.stable[IN_RRQ]) ||
          (shutdownPoweroffStart && st_r.ctrl[C_POFFRST])) begin
         st_nxt.hostRstAct = 1'b1;
         st_nxt.rtRun      = 1'b0;
      end else if (st_r.hostRstAct) begin
         // only the selected trigger starts the release timer
         unique case (pkrc_trig_e'(st_r.ctrl[C_TRIG_LSB +: 2]))
            PKRC_TRIG_WAKE:  trigHit = externalWakeTrigger;
            PKRC_TRIG_FIRST: trigHit = firstSubseqDone;
            PKRC_TRIG_SECND: trigHit = secondSubseqDone;
            PKRC_TRIG_POFF:  trigHit = resetToPoweroffDone;
         endcase
         // zero setting releases at once, otherwise count ms ticks
         if (trigHit && st_r.resetTimer == '0) begin
            st_nxt.hostRstAct = 1'b0;
         end else if (trigHit) begin
            st_nxt.rtRun = 1'b1;
            st_nxt.rtCnt = '0;
         end else if (st_r.rtRun && st_r.rtCnt >= st_r.resetTimer) begin
            st_nxt.hostRstAct = 1'b0;
            st_nxt.rtRun      = 1'b0;
         end else if (st_r.rtRun && st_r.tick) begin
            st_nxt.rtCnt = st_r.rtCnt + RT_W'(1);
         end
      end

      // pin drivers, push-pull or open drain
      irqAct = st_nxt.keyEvent && !st_nxt.ctrl[C_MASK];
      // open drain pulls low only while active, push-pull always drives
      if (st_nxt.ctrl[C_ODRAIN]) begin
         st_nxt.hostResetOut = 1'b0;
         st_nxt.hostResetOe  = st_nxt.hostRstAct;
         st_nxt.irqOut       = 1'b0;
         st_nxt.irqOe        = irqAct;
      end else begin
         st_nxt.hostResetOut = !st_nxt.hostRstAct;
         st_nxt.hostResetOe  = 1'b1;
         // xnor with the polarity bit gives the active level
         st_nxt.irqOut       = irqAct ~^ st_nxt.ctrl[C_IRQHIGH];
         st_nxt.irqOe        = 1'b1;
      end
   end

   // state register; cold boot comes up with host reset held
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // everything not named below, the apb answer too, starts at zero
         st_r              <= '0;
         st_r.stable       <= '1;
         st_r.debounceSel  <= DB_RST;
         st_r.keyDelay     <= KD_RST;
         st_r.resetTimer   <= RT_RST;
         st_r.keySt        <= PKRC_KEY_IDLE;
         st_r.hostRstAct   <= 1'b1;
         st_r.hostResetOe  <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign prdata       = st_r.prdata;
   assign pready       = st_r.pready;
   assign pslverr      = st_r.pslverr;
   assign wakeReq      = st_r.wakeReq;
   assign resetModeReq = st_r.resetModeReq;
   assign fastShutdown = st_r.ctrl[C_FAST];
   assign systemRunReq = st_r.ctrl[C_SYSRUN];
   assign lowPowerReq  = st_r.ctrl[C_LOWPWR];
   assign hostResetOut = st_r.hostResetOut;
   assign hostResetOe  = st_r.hostResetOe;
   assign irqOut       = st_r.irqOut;
   assign irqOe        = st_r.irqOe;
endmodule

/* File: tb/pkrc_sva.sv */
/* checker on the pkrc_top ports: apb answer, reset request, host reset,
   wake pulse and irq release.
   assumes one clock mclk and the asynchronous active low reset rst_n. */
`timescale 1ns/1ns
module pkrc_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic resetRequestIn,
   input wire logic powerOffState,
   input wire logic shutdownResetStart,
   input wire logic wakeReq,
   input wire logic resetModeReq,
   input wire logic fastShutdown,
   input wire logic hostResetOut,
   input wire logic hostResetOe,
   input wire logic irqOe
);
   // host reset driven low, and a write taking effect
   wire hrAct = hostResetOe & ~hostResetOut;
   wire apbWr = psel & penable & pwrite;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // apb answer timing, then the rule relations
   property p_apb_ans; psel && !penable |=> pready; endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("pready missing after setup");
   property p_apb_one; pready |=> !pready; endproperty
   a_apb_one: assert property (p_apb_one) else $error("pready held too long");
   property p_rrq_src; resetModeReq |-> !$past(resetRequestIn); endproperty
   a_rrq_src: assert property (p_rrq_src) else $error("reset mode without request");
   property p_rrq_pulse; resetModeReq |=> !resetModeReq; endproperty
   a_rrq_pulse: assert property (p_rrq_pulse) else $error("reset mode pulse long");
   property p_rrq_hr; resetModeReq |-> ##[0:2] hrAct; endproperty
   a_rrq_hr: assert property (p_rrq_hr) else $error("host reset not driven");
   property p_sd_hr; shutdownResetStart |-> ##[1:3] hrAct; endproperty
   a_sd_hr: assert property (p_sd_hr) else $error("host reset not driven");
   property p_fast; $changed(fastShutdown) |-> $past(apbWr); endproperty
   a_fast: assert property (p_fast) else $error("fast shutdown moved alone");
   property p_wake_off; wakeReq |-> powerOffState || $past(powerOffState); endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake outside power off");
   property p_irq_hold; $fell(irqOe) |-> $past(apbWr) || $past(apbWr, 2); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq released alone");

   // main scenarios reached
   c_wake: cover property (wakeReq);
   c_rrq: cover property (resetModeReq);
   c_irq: cover property ($fell(irqOe));
endmodule

bind pkrc_top pkrc_sva i_pkrc_sva (.mclk, .rst_n, .psel, .penable, .pwrite, .pready,
   .resetRequestIn, .powerOffState, .shutdownResetStart, .wakeReq, .resetModeReq,
   .fastShutdown, .hostResetOut, .hostResetOe, .irqOe);

/* File: tb/pkrc_button_model.sv */
/* power key and reset request buttons: contact bounce, a held level,
   bounce again, then the pulled-up idle level.
   assumes the bench calls hit from one process at a time. */
`timescale 1ns/1ns
module pkrc_button_model (
   input wire logic mclk,
   output logic     powerKeyIn,
   output logic     resetRequestIn
);
   // both buttons idle high through their pull-ups
   initial begin
      powerKeyIn = 1'b1;
      resetRequestIn = 1'b1;
   end

   // one press of len cycles framed by short bounce bursts
   task automatic hit(input bit rrq, input int len);
      logic v;
      for (int i = 0; i < len + 12; i++) begin
         @(posedge mclk);
         v = (i >= 6 && i < len + 6) ? 1'b0 : i[1];
         if (rrq) resetRequestIn <= v;
         else powerKeyIn <= v;
      end
      @(posedge mclk);
      if (rrq) resetRequestIn <= 1'b1;
      else powerKeyIn <= 1'b1;
   endtask
endmodule

/* File: tb/pkrc_top_tb.sv */
/* self-checking bench for pkrc_top: apb master, sequencer pulses, buttons.
   assumes pkrc_sva is bound from its own file; one millisecond is 10 cycles. */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module pkrc_top_tb
   import pkrc_pkg::*;
;
   localparam int MS = 10;
   localparam int P_SDR = 4;                    // pulse bit of shutdownResetStart
   localparam int P_SDP = 5;                    // pulse bit of shutdownPoweroffStart
   typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} pkrc_exp_s;
   logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, seed, ex;
   logic              powerKeyIn, resetRequestIn, powerOffState, seqBusy;
   logic              externalWakeTrigger, firstSubseqDone, secondSubseqDone;
   logic              resetToPoweroffDone, shutdownResetStart, shutdownPoweroffStart;
   logic [5:0]        pls;
   logic              wakeReq, resetModeReq, fastShutdown, systemRunReq, lowPowerReq;
   logic              hostResetOut, hostResetOe, irqOut, irqOe;
   pkrc_exp_s         expQ[$];
   int                n_errors, n_checks, nWake, nRrq, w0;
   wire               hrAct = hostResetOe & ~hostResetOut;

   // sequencer pulses, one bit each, the four triggers in select order first
   assign {shutdownPoweroffStart, shutdownResetStart, resetToPoweroffDone,
           secondSubseqDone, firstSubseqDone, externalWakeTrigger} = pls;

   pkrc_top #(.MS_CYCLES(MS)) i_pkrc_top (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .powerKeyIn, .resetRequestIn, .powerOffState,
      .seqBusy, .externalWakeTrigger, .firstSubseqDone, .secondSubseqDone,
      .resetToPoweroffDone, .shutdownResetStart, .shutdownPoweroffStart, .wakeReq,
      .resetModeReq, .fastShutdown, .systemRunReq, .lowPowerReq, .hostResetOut,
      .hostResetOe, .irqOut, .irqOe);
   pkrc_button_model i_pkrc_button_model (.mclk, .powerKeyIn, .resetRequestIn);

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // one apb transfer held until pready is sampled high
   task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
      expQ.push_back('{32'h0, 32'h0, 1'b0});
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] v, m, input logic e);
      expQ.push_back('{v, m, e});
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input int k);
      @(posedge mclk);
      pls <= 6'(1 << k);
      @(posedge mclk);
      pls <= '0;
   endtask
   task automatic press(input int len);
      i_pkrc_button_model.hit(1'b0, len);
      repeat (40) @(posedge mclk);
   endtask

   // drive host reset low, fire trigger t, time the release
   task automatic trig(input int t, input int ms);
      int n;
      pulse(P_SDR);
      repeat (3) @(posedge mclk);
      `CHK(hrAct, 1'b1)
      pulse(t);
      n = 0;
      while (hrAct && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      `CHK(n + MS >= ms * MS && n <= ms * MS + 4, 1'b1)
   endtask

   // take the oldest note at each answer and count wake and reset pulses
   always @(posedge mclk) begin
      if (psel && penable && pready) begin
         pkrc_exp_s x;
         x = expQ.pop_front();
         `CHK(prdata & x.m, x.v & x.m)
         `CHK(pslverr, x.e)
      end
      if (wakeReq === 1'b1) nWake++;
      if (resetModeReq === 1'b1) nRrq++;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      stop_test();
   end

   // main sequence
   initial begin
      {psel, penable, pwrite, powerOffState, seqBusy} = '0;
      pls = '0;
      paddr = '0;
      pwdata = '0;
      seed = 32'h0000_7788;
      rst_n = 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      `CHK(hrAct, 1'b1)
      rd(ADDR_CTRL, 32'h0, 32'hFFF, 1'b0);
      rd(ADDR_TIMING, {2'h0, RT_RST, KD_RST, DB_RST}, 32'hFFFF_FFFF, 1'b0);
      rd(ADDR_STATUS, 32'h4, 32'h4, 1'b0);
      rd(12'h020, 32'h0, 32'hFFFF_FFFF, 1'b1);
      wr(ADDR_TIMING, 32'h0030_0802);
      rd(ADDR_TIMING, 32'h0030_0802, 32'hFFFF_FFFF, 1'b0);
      $display("test registers done");
      trig(0, 3);
      pulse(P_SDP);
      repeat (3) @(posedge mclk);
      `CHK(hrAct, 1'b0)
      wr(ADDR_CTRL, 32'h1 << C_POFFRST);
      pulse(P_SDP);
      repeat (3) @(posedge mclk);
      `CHK(hrAct, 1'b1)
      wr(ADDR_TIMING, 32'h0000_0802);
      for (int t = 0; t < 4; t++) begin
         wr(ADDR_CTRL, t << C_TRIG_LSB);
         trig(t, 0);
      end
      $display("test host reset done");
      powerOffState <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_CTRL, m | 32'h400);
         w0 = nWake;
         press(34 + xs() % 10);
         rd(ADDR_EVENT, 32'h1, 32'h1, 1'b0);
         `CHK(irqOut, 1'b0)
         if (m == 0) `CHK(nWake > w0, 1'b1)
         `CHK({systemRunReq, lowPowerReq}, m == 3 ? 2'b01 : 2'b10)
         wr(ADDR_EVENT, 32'h1);
         repeat (3) @(posedge mclk);
         `CHK(irqOut, 1'b1)
         wr(ADDR_CTRL, m | 32'h400);
         press(150);
         ex = m | (32'(m != 0) << C_LOCK) | (32'(m < 2) << C_SYSRUN);
         rd(ADDR_EVENT, 32'h1, 32'h1, 1'b0);
         rd(ADDR_CTRL, ex, 32'hC0B, 1'b0);
         wr(ADDR_EVENT, 32'h1);
      end
      $display("test key modes done");
      wr(ADDR_CTRL, 32'h9);
      w0 = nWake;
      press(40);
      `CHK(nWake, w0)
      press(150);
      `CHK(nWake > w0, 1'b1)
      powerOffState <= 1'b0;
      wr(ADDR_CTRL, 32'h1);
      powerOffState <= 1'b1;
      w0 = nWake;
      press(40);
      `CHK(nWake > w0, 1'b1)
      wr(ADDR_CTRL, 32'h4);
      wr(ADDR_EVENT, 32'h1);
      w0 = nWake;
      press(40);
      rd(ADDR_EVENT, 32'h1, 32'h1, 1'b0);
      `CHK({irqOut, nWake == w0}, 2'b11)
      wr(ADDR_EVENT, 32'h1);
      wr(ADDR_CTRL, 32'h0);
      press(2);
      rd(ADDR_EVENT, 32'h0, 32'h1, 1'b0);
      rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
      $display("test lock and mask done");
      press(40);
      wr(ADDR_CTRL, 32'h1 << C_IRQHIGH);
      repeat (3) @(posedge mclk);
      `CHK({irqOut, irqOe}, 2'b11)
      wr(ADDR_CTRL, 32'h1 << C_ODRAIN);
      repeat (3) @(posedge mclk);
      `CHK({irqOut, irqOe, hostResetOe}, 3'b010)
      wr(ADDR_EVENT, 32'h1);
      repeat (3) @(posedge mclk);
      `CHK(irqOe, 1'b0)
      wr(ADDR_CTRL, 32'h0);
      seqBusy <= 1'b1;
      press(40);
      rd(ADDR_STATUS, 32'h10, 32'h10, 1'b0);
      rd(ADDR_EVENT, 32'h0, 32'h1, 1'b0);
      seqBusy <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(ADDR_EVENT, 32'h1, 32'h1, 1'b0);
      wr(ADDR_EVENT, 32'h1);
      $display("test irq done");
      wr(ADDR_CTRL, 32'h1 << C_FAST);
      repeat (2) @(posedge mclk);
      `CHK(fastShutdown, 1'b1)
      w0 = nRrq;
      i_pkrc_button_model.hit(1'b1, 40);
      repeat (40) @(posedge mclk);
      `CHK(nRrq, w0 + 1)
      `CHK(hrAct, 1'b1)
      rd(ADDR_FAULT, 32'h1, 32'h1, 1'b0);
      wr(ADDR_FAULT, 32'h1);
      rd(ADDR_FAULT, 32'h0, 32'h1, 1'b0);
      $display("test reset request done");
      stop_test();
   end
endmodule
